//--- inc/port_pin_pkg.sv
// shared constants and carrier types for the port pin configuration block
package port_pin_pkg;

  // register addresses and pages
  localparam logic [7:0] ADDR_P1_DATA  = 8'h90;
  localparam logic [7:0] ADDR_OUT_TYPE = 8'hA4;
  localparam logic [7:0] ADDR_DRIVE    = 8'hA4;
  localparam logic [7:0] ADDR_BYPASS   = 8'hD5;
  localparam logic [7:0] ADDR_ANALOG   = 8'hF1;
  localparam logic [3:0] PAGE_CFG      = 4'h0;
  localparam logic [3:0] PAGE_DRV      = 4'hF;

  // reset values
  localparam logic [7:0] RST_LATCH    = 8'hFF;
  localparam logic [7:0] RST_ANALOG   = 8'hFF;
  localparam logic [7:0] RST_OUT_TYPE = 8'h00;
  localparam logic [7:0] RST_DRIVE    = 8'h00;
  localparam logic [7:0] RST_BYPASS   = 8'h00;

  // field positions
  localparam int unsigned BIT_VAL_POS = 0;

  // one special function register access, held for a single cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic       bit_op;
    logic [2:0] bit_idx;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // registered read answer
  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [7:0] data;
  } sfr_rsp_s;

  // pad drive controls for one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
    logic [7:0] receiver_en;
    logic [7:0] drive_high;
  } pad_ctrl_s;

endpackage

//--- hw/sfr_byte.sv
// one byte-wide special function register with page decode and bit writes
`timescale 1ns/1ns
module sfr_byte
  import port_pin_pkg::*;
#(
  parameter logic [7:0] ADDR     = 8'h00,
  parameter logic [3:0] PAGE     = 4'h0,
  parameter bit         ANY_PAGE = 1'b0,
  parameter bit         BIT_ADDR = 1'b0,
  parameter logic [7:0] RESET    = 8'h00
) (
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     arst_n,
  // access
  input  wire sfr_req_s req,
  output logic          sel,
  output logic [7:0]    q
);

  // page is ignored for registers visible on every page
  assign sel = (req.addr == ADDR) && (ANY_PAGE || (req.page == PAGE));

  // bit writes reach only bit-addressable registers; others ignore them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RESET;
    end else if (req.wr && sel) begin
      if (!req.bit_op) begin
        q <= req.wdata;
      end else if (BIT_ADDR) begin
        q[req.bit_idx] <= req.wdata[BIT_VAL_POS];
      end
    end
  end

endmodule

//--- hw/port_pin_config.sv
// pin configuration and data logic for port 0 and port 1
//
// Contract
// - a 0 in port0_analog_select puts its pin in analog mode without pullup or receiver.
// - port0_output_type bit 0 gives open-drain, 1 push-pull, even on analog pins.
// - port0_drive_strength bit 0 selects low drive, 1 selects high drive.
// - output type decodes at 0xA4 on page 0x0, drive strength at 0xA4 on page 0xF.
// - a write to port1_data_latch loads each written bit into that pin's latch.
// - a plain read of port1_data_latch returns the digital pin levels, not the latch.
// - port1_data_latch answers at 0x90 on every page, by byte or by single bit.
// - a 1 in port1_crossbar_bypass makes the crossbar skip that pin.
// - reset leaves analog select all 1, type and drive all 0, latch all 1, bypass all 0.
// - read-modify-write accesses read the latch rather than the pin level.
// - two-wire serial bus pins are always open-drain whatever their type bit.
`timescale 1ns/1ns
module port_pin_config
  import port_pin_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // special function register access
  input  wire sfr_req_s   sfr_req,
  output sfr_rsp_s        sfr_rsp,
  // port 0 pads
  input  wire logic [7:0] port0_out_data,
  input  wire logic [7:0] port0_twowire,
  input  wire logic [7:0] port0_pin_in,
  output pad_ctrl_s       port0_pad,
  output logic [7:0]      port0_pin_level,
  // port 1 pads and crossbar
  input  wire logic [7:0] port1_pin_in,
  input  wire logic [7:0] port1_receiver_en,
  output logic [7:0]      port1_latch_out,
  output logic [7:0]      port1_skip
);

  logic [7:0] analog_q;
  logic [7:0] type_q;
  logic [7:0] drive_q;
  logic [7:0] latch_q;
  logic [7:0] bypass_q;
  logic       analog_sel;
  logic       type_sel;
  logic       drive_sel;
  logic       latch_sel;
  logic       bypass_sel;
  logic [7:0] push_pull;
  logic [7:0] p1_level;
  logic [7:0] rd_next;
  logic       hit_next;

  // configuration registers, each decoded by address and, except the port 1 latch, by page
  sfr_byte #(
    .ADDR(ADDR_ANALOG), .PAGE(PAGE_CFG), .ANY_PAGE(1'b0), .BIT_ADDR(1'b0), .RESET(RST_ANALOG)
  ) u_analog (
    .mclk(mclk), .arst_n(arst_n), .req(sfr_req), .sel(analog_sel), .q(analog_q)
  );

  sfr_byte #(
    .ADDR(ADDR_OUT_TYPE), .PAGE(PAGE_CFG), .ANY_PAGE(1'b0), .BIT_ADDR(1'b0), .RESET(RST_OUT_TYPE)
  ) u_out_type (
    .mclk(mclk), .arst_n(arst_n), .req(sfr_req), .sel(type_sel), .q(type_q)
  );

  sfr_byte #(
    .ADDR(ADDR_DRIVE), .PAGE(PAGE_DRV), .ANY_PAGE(1'b0), .BIT_ADDR(1'b0), .RESET(RST_DRIVE)
  ) u_drive (
    .mclk(mclk), .arst_n(arst_n), .req(sfr_req), .sel(drive_sel), .q(drive_q)
  );

  sfr_byte #(
    .ADDR(ADDR_P1_DATA), .PAGE(PAGE_CFG), .ANY_PAGE(1'b1), .BIT_ADDR(1'b1), .RESET(RST_LATCH)
  ) u_latch (
    .mclk(mclk), .arst_n(arst_n), .req(sfr_req), .sel(latch_sel), .q(latch_q)
  );

  sfr_byte #(
    .ADDR(ADDR_BYPASS), .PAGE(PAGE_CFG), .ANY_PAGE(1'b0), .BIT_ADDR(1'b0), .RESET(RST_BYPASS)
  ) u_bypass (
    .mclk(mclk), .arst_n(arst_n), .req(sfr_req), .sel(bypass_sel), .q(bypass_q)
  );

  // port 0 pad controls; analog mode leaves the driver alone on purpose
  assign push_pull             = type_q & ~port0_twowire;
  assign port0_pad.oe          = push_pull | ~port0_out_data;
  assign port0_pad.out         = port0_out_data & push_pull;
  assign port0_pad.pullup_en   = analog_q;
  assign port0_pad.receiver_en = analog_q;
  assign port0_pad.drive_high  = drive_q;
  assign port0_pin_level       = port0_pin_in & analog_q;

  // port 1 latch and crossbar skip go straight out of their registers
  assign port1_latch_out = latch_q;
  assign port1_skip      = bypass_q;
  // an analog pin has no digital receiver and so reads low
  assign p1_level        = port1_pin_in & port1_receiver_en;

  // read select; read-modify-write sees the latch so open-drain highs survive
  always_comb begin
    rd_next  = 8'h00;
    hit_next = 1'b1;
    if (latch_sel) begin
      rd_next = sfr_req.rmw ? latch_q : p1_level;
    end else if (type_sel) begin
      rd_next = type_q;
    end else if (drive_sel) begin
      rd_next = drive_q;
    end else if (bypass_sel) begin
      rd_next = bypass_q;
    end else if (analog_sel) begin
      rd_next = analog_q;
    end else begin
      hit_next = 1'b0;
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rsp <= '0;
    end else begin
      sfr_rsp.valid <= sfr_req.rd;
      sfr_rsp.hit   <= sfr_req.rd & hit_next;
      sfr_rsp.data  <= sfr_req.rd ? rd_next : 8'h00;
    end
  end

  // helper: marks the first edge after reset release
  logic boot_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_analog_write: assert property (
    sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == ADDR_ANALOG && sfr_req.page == PAGE_CFG
    |=> port0_pad.receiver_en == $past(sfr_req.wdata)
        && port0_pad.pullup_en == $past(sfr_req.wdata))
    else $error("analog select write did not reach receiver and pullup");

  a_analog_drives: assert property (
    (port0_pad.oe & type_q & ~port0_twowire) == (type_q & ~port0_twowire)
    && (port0_pad.out & type_q & ~port0_twowire)
       == (port0_out_data & type_q & ~port0_twowire))
    else $error("push-pull pin not driven");

  a_drive_page: assert property (
    sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == ADDR_DRIVE && sfr_req.page == PAGE_DRV
    |=> port0_pad.drive_high == $past(sfr_req.wdata) && $stable(type_q))
    else $error("page F write at A4 did not hit drive strength only");

  a_type_page: assert property (
    sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == ADDR_OUT_TYPE && sfr_req.page == PAGE_CFG
    |=> type_q == $past(sfr_req.wdata) && $stable(drive_q))
    else $error("page 0 write at A4 did not hit output type only");

  a_latch_bit: assert property (
    sfr_req.wr && sfr_req.bit_op && sfr_req.addr == ADDR_P1_DATA
    |=> port1_latch_out[$past(sfr_req.bit_idx)] == $past(sfr_req.wdata[0]))
    else $error("bit write to port 1 latch lost");

  a_latch_byte: assert property (
    sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == ADDR_P1_DATA
    |=> port1_latch_out == $past(sfr_req.wdata))
    else $error("byte write to port 1 latch lost");

  a_pin_read: assert property (
    sfr_req.rd && !sfr_req.rmw && sfr_req.addr == ADDR_P1_DATA
    |=> sfr_rsp.valid && sfr_rsp.hit
        && sfr_rsp.data == ($past(port1_pin_in) & $past(port1_receiver_en)))
    else $error("port 1 read did not return pin levels");

  a_rmw_latch: assert property (
    sfr_req.rd && sfr_req.rmw && sfr_req.addr == ADDR_P1_DATA
    |=> sfr_rsp.data == $past(latch_q))
    else $error("read-modify-write did not read the latch");

  a_bypass_write: assert property (
    sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == ADDR_BYPASS && sfr_req.page == PAGE_CFG
    |=> port1_skip == $past(sfr_req.wdata))
    else $error("bypass write did not reach the crossbar");

  a_reset_vals: assert property (
    boot_reg |-> analog_q == RST_ANALOG && type_q == RST_OUT_TYPE && drive_q == RST_DRIVE
                 && port1_latch_out == RST_LATCH && port1_skip == RST_BYPASS)
    else $error("register not at reset value after reset");

  a_twowire_od: assert property (
    (port0_pad.out & port0_twowire) == 8'h00
    && ((port0_pad.oe & port0_twowire) == (~port0_out_data & port0_twowire)))
    else $error("two-wire pin driven push-pull");

  a_od_release: assert property (
    (port0_pad.oe & ~push_pull) == (~port0_out_data & ~push_pull))
    else $error("open-drain pin not released for a high");

  a_drive_sel: assert property (
    sfr_req.wr && sfr_req.page != PAGE_DRV |=> $stable(port0_pad.drive_high))
    else $error("drive strength changed off its page");

endmodule

//--- test/port_pad_model.sv
// stand-in for the pads and outside drivers of both ports
`timescale 1ns/1ns
module port_pad_model
  import port_pin_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // pad controls from the block, and the outside pull-downs on port 1
  input  wire pad_ctrl_s  port0_pad,
  input  wire logic [7:0] port1_latch_out,
  input  wire logic [7:0] port1_ext_low,
  // resolved pad levels
  output logic [7:0]      port0_pin_in,
  output logic [7:0]      port1_pin_in
);
  logic [7:0] float_pat = 8'h5A;

  // an undriven pad without pullup wanders, so no stale level can be trusted
  always_ff @(posedge mclk) begin
    float_pat <= ~float_pat;
  end

  // driven pads follow out, released ones go to the pullup or float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port0_pin_in[i] = port0_pad.oe[i] ? port0_pad.out[i] :
                        (port0_pad.pullup_en[i] ? 1'b1 : float_pat[i]);
    end
  end

  // port 1 pads are open-drain with pullup; outside parties may pull low
  assign port1_pin_in = port1_latch_out & ~port1_ext_low;
endmodule

//--- test/port_pin_config_tb.sv
// self-checking bench for the port pin configuration block
`timescale 1ns/1ns
module port_pin_config_tb;
  import port_pin_pkg::*;
  logic       mclk              = 1'b0;
  logic       arst_n            = 1'b0;
  sfr_req_s   sfr_req           = '0;
  logic [7:0] port0_out_data    = 8'hF0;
  logic [7:0] port0_twowire     = 8'h04;
  logic [7:0] port1_receiver_en = 8'hFF;
  logic [7:0] port1_ext_low     = 8'h00;
  sfr_rsp_s   sfr_rsp;
  pad_ctrl_s  port0_pad;
  logic [7:0] port0_pin_in;
  logic [7:0] port1_pin_in;
  logic [7:0] port0_pin_level;
  logic [7:0] port1_latch_out;
  logic [7:0] port1_skip;
  logic [7:0] rd_data;
  logic       rd_hit;
  int         fail_count        = 0;
  int         check_count       = 0;
  int         cycles            = 0;

  always #4 mclk = ~mclk;

  port_pin_config u_port_pin_config (.mclk(mclk), .arst_n(arst_n), .sfr_req(sfr_req),
    .sfr_rsp(sfr_rsp), .port0_out_data(port0_out_data), .port0_twowire(port0_twowire),
    .port0_pin_in(port0_pin_in), .port0_pad(port0_pad), .port0_pin_level(port0_pin_level),
    .port1_pin_in(port1_pin_in), .port1_receiver_en(port1_receiver_en),
    .port1_latch_out(port1_latch_out), .port1_skip(port1_skip));

  port_pad_model u_port_pad_model (.mclk(mclk), .port0_pad(port0_pad),
    .port1_latch_out(port1_latch_out), .port1_ext_low(port1_ext_low),
    .port0_pin_in(port0_pin_in), .port1_pin_in(port1_pin_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one access held for a single edge, then an idle edge so strobes never re-fire at once
  task automatic acc(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] wdata,
                     input logic [3:0] kind, input logic [2:0] idx);
    sfr_req = '{wr: kind[3], rd: kind[2], rmw: kind[1], bit_op: kind[0], bit_idx: idx,
                page: page, addr: addr, wdata: wdata};
    @(posedge mclk);
    #1;
    sfr_req = '0;
    rd_data = sfr_rsp.data;
    rd_hit  = sfr_rsp.valid & sfr_rsp.hit;
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [3:0] page, input logic [7:0] addr, input logic rmw,
                    input logic [7:0] exp, input logic exp_hit);
    acc(page, addr, 8'h00, {2'b01, rmw, 1'b0}, 3'h0);
    chk(rd_data, exp, "read data");
    chk({7'h00, rd_hit}, {7'h00, exp_hit}, "read hit");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // cut a hang short, far beyond the 58 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    @(posedge mclk);
    #1;
    // reset state at the pads and in the registers
    chk(port0_pad.pullup_en, 8'hFF, "pullup");
    chk(port0_pad.drive_high, 8'h00, "drive");
    chk(port0_pad.oe, 8'h0F, "oe");
    chk(port1_latch_out, 8'hFF, "latch");
    chk(port1_skip, 8'h00, "skip");
    rd(PAGE_CFG, 8'hF1, 1'b0, 8'hFF, 1'b1);
    rd(PAGE_CFG, 8'hA4, 1'b0, 8'h00, 1'b1);
    rd(4'hF, 8'hA4, 1'b0, 8'h00, 1'b1);
    // port 0 modes, with analog pins still under type control
    acc(PAGE_CFG, 8'hF1, 8'h0F, 4'h8, 3'h0);
    acc(PAGE_CFG, 8'hA4, 8'h3C, 4'h8, 3'h0);
    acc(4'hF, 8'hA4, 8'hA5, 4'h8, 3'h0);
    chk(port0_pad.pullup_en, 8'h0F, "pullup");
    chk(port0_pad.receiver_en, 8'h0F, "receiver");
    chk(port0_pad.oe, 8'h3F, "oe");
    chk(port0_pad.out, 8'h30, "out");
    chk(port0_pad.drive_high, 8'hA5, "drive");
    chk(port0_pin_level, 8'h00, "level");
    port0_out_data = 8'h0F;
    #1;
    chk(port0_pad.oe, 8'hF8, "oe");
    chk(port0_pad.out, 8'h08, "out");
    chk(port0_pin_level, 8'h0F, "level");
    rd(PAGE_CFG, 8'hA4, 1'b0, 8'h3C, 1'b1);
    rd(4'hF, 8'hA4, 1'b0, 8'hA5, 1'b1);
    rd(4'h3, 8'hA4, 1'b0, 8'h00, 1'b0);
    // port 1 latch by byte and by bit on several pages
    acc(4'hF, 8'h90, 8'h55, 4'h8, 3'h0);
    chk(port1_latch_out, 8'h55, "latch");
    acc(4'h7, 8'h90, 8'h00, 4'h9, 3'h4);
    chk(port1_latch_out, 8'h45, "bit clear");
    acc(PAGE_CFG, 8'h90, 8'h01, 4'h9, 3'h7);
    chk(port1_latch_out, 8'hC5, "bit set");
    port1_ext_low = 8'h81;
    port1_receiver_en = 8'h7F;
    rd(4'h2, 8'h90, 1'b0, 8'h44, 1'b1);
    rd(4'h2, 8'h90, 1'b1, 8'hC5, 1'b1);
    // crossbar bypass, as software sets it for plain I/O pins
    acc(PAGE_CFG, 8'hD5, 8'h01, 4'h9, 3'h0);
    chk(port1_skip, 8'h00, "skip");
    acc(PAGE_CFG, 8'hD5, 8'hFF, 4'h8, 3'h0);
    chk(port1_skip, 8'hFF, "skip");
    rd(4'hF, 8'hD5, 1'b0, 8'h00, 1'b0);
    rd(PAGE_CFG, 8'h80, 1'b0, 8'h00, 1'b0);
    // reset again in mid-run
    arst_n = 1'b0;
    @(posedge mclk);
    #1;
    chk(port1_skip, 8'h00, "skip");
    chk(port1_latch_out, 8'hFF, "latch");
    chk(port0_pad.drive_high, 8'h00, "drive");
    arst_n = 1'b1;
    // first accesses right after the second release see reset contents
    rd(4'h5, 8'h90, 1'b0, 8'h7E, 1'b1);
    rd(PAGE_CFG, 8'hD5, 1'b0, 8'h00, 1'b1);
    summarize();
  end
endmodule
